// ===== hdl/acc_regs.vh
// register offsets, field positions, reset values for the comparator control block
// assumes a 32-bit apb slave with byte addresses
`ifndef ACC_REGS_VH
`define ACC_REGS_VH

`define ACC_CTRL_IDX      8'h9b
`define ACC_CTRL_ADDR     12'h26c
`define ACC_MODE_ADDR     12'h270
`define ACC_IRQ_STAT_ADDR 12'h274
`define ACC_IRQ_MASK_ADDR 12'h278

`define ACC_CTRL_RESET    8'h00
`define ACC_MODE_RESET    2'h0
`define ACC_BIT_ON        7
`define ACC_BIT_RESULT    6
`define ACC_BIT_RISE      5
`define ACC_BIT_FALL      4
`define ACC_POS_HI        3
`define ACC_POS_LO        2
`define ACC_NEG_HI        1
`define ACC_NEG_LO        0
`define ACC_IRQ_RISE      0
`define ACC_IRQ_FALL      1

`endif

// ===== hdl/acc_edge_sync.v
// two-stage synchroniser and edge detector for the comparator output
// assumes the raw comparator output is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none

module acc_edge_sync
(
  input  wire clk,
  input  wire rst,
  input  wire raw_in,
  output reg  level_ff,
  output wire rise,
  output wire fall
);

  reg meta_ff;
  reg sync_ff;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_ff  <= 1'b0;
      sync_ff  <= 1'b0;
      level_ff <= 1'b0;
    end
    else
    begin
      meta_ff  <= raw_in;
      sync_ff  <= meta_ff;
      level_ff <= sync_ff;
    end
  end

  assign rise = sync_ff & ~level_ff;
  assign fall = ~sync_ff & level_ff;

endmodule

`default_nettype wire

// ===== hdl/acc_top.v
// comparator control and status block with apb register access
// assumes the analog comparator core sits outside and drives cmp_raw
//
// Functional notes
// - bit 7 turns the comparator on/off
// - bit 6 reads live comparator result
// - rising output sets rise flag bit 5
// - falling output sets fall flag bit 4
// - edge flags stay set until software clears
// - interrupts from both rising and falling edges
// - rise request forwarded only when mask enabled
// - fall request forwarded only when mask enabled
// - bits 3:2 select positive hysteresis
// - bits 1:0 select negative hysteresis
// - mode register selects response time
// - spurious edges possible after setting changes
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.vh"

module acc_top
(
  input  wire        clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        cmp_raw,
  output reg         comparator_on,
  output reg  [1:0]  pos_hyst_sel,
  output reg  [1:0]  neg_hyst_sel,
  output reg  [1:0]  response_mode,
  output reg         irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg        rise_edge_flag_ff;
  reg        fall_edge_flag_ff;
  reg        rise_irq_mask_en_ff;
  reg        fall_irq_mask_en_ff;
  reg        rise_stat_ff;
  reg        fall_stat_ff;
  wire       cmp_level;
  wire       cmp_rise;
  wire       cmp_fall;
  wire       wr_go;
  wire       rd_go;
  wire       lane0;
  reg        nxt_rise_flag;
  reg        nxt_fall_flag;
  reg        nxt_rise_stat;
  reg        nxt_fall_stat;
  reg        nxt_rise_mask;
  reg        nxt_fall_mask;
  reg [31:0] nxt_prdata;
  reg        nxt_slverr;

  function addr_known;
    input [11:0] a;
    begin
      addr_known = (a == `ACC_CTRL_ADDR) || (a == `ACC_MODE_ADDR) ||
                   (a == `ACC_IRQ_STAT_ADDR) || (a == `ACC_IRQ_MASK_ADDR);
    end
  endfunction

  // ----------------------------------------------------------------
  // comparator synchroniser
  // ----------------------------------------------------------------
  acc_edge_sync u_sync
  (
    .clk      (clk),
    .rst      (rst),
    .raw_in   (cmp_raw),
    .level_ff (cmp_level),
    .rise     (cmp_rise),
    .fall     (cmp_fall)
  );

  // access phase, one wait cycle; single-cycle pready pulse
  assign wr_go = psel & penable & pwrite & ~pready;
  assign rd_go = psel & penable & ~pwrite & ~pready;
  assign lane0 = pstrb[0];

  // ----------------------------------------------------------------
  // flag and status next values
  // ----------------------------------------------------------------
  always @*
  begin
    nxt_rise_flag = rise_edge_flag_ff;
    nxt_fall_flag = fall_edge_flag_ff;
    nxt_rise_stat = rise_stat_ff;
    nxt_fall_stat = fall_stat_ff;
    nxt_rise_mask = rise_irq_mask_en_ff;
    nxt_fall_mask = fall_irq_mask_en_ff;
    // a mask write must reach irq in the same cycle as the mask itself
    if (wr_go && lane0 && paddr == `ACC_IRQ_MASK_ADDR)
    begin
      nxt_rise_mask = pwdata[`ACC_IRQ_RISE];
      nxt_fall_mask = pwdata[`ACC_IRQ_FALL];
    end
    // software writes flags directly; hardware set wins afterwards
    // power-up or setting changes may leave spurious edges here
    if (wr_go && lane0 && paddr == `ACC_CTRL_ADDR)
    begin
      nxt_rise_flag = pwdata[`ACC_BIT_RISE];
      nxt_fall_flag = pwdata[`ACC_BIT_FALL];
    end
    if (wr_go && lane0 && paddr == `ACC_IRQ_STAT_ADDR)
    begin
      if (pwdata[`ACC_IRQ_RISE])
        nxt_rise_stat = 1'b0;
      if (pwdata[`ACC_IRQ_FALL])
        nxt_fall_stat = 1'b0;
    end
    if (cmp_rise)
    begin
      nxt_rise_flag = 1'b1;
      nxt_rise_stat = 1'b1;
    end
    if (cmp_fall)
    begin
      nxt_fall_flag = 1'b1;
      nxt_fall_stat = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always @*
  begin
    nxt_prdata = 32'h0000_0000;
    nxt_slverr = 1'b0;
    if (psel && penable && !pready)
    begin
      nxt_slverr = ~addr_known(paddr);
      if (rd_go)
      begin
        case (paddr)
          `ACC_CTRL_ADDR:
          begin
            nxt_prdata[`ACC_BIT_ON]     = comparator_on;
            nxt_prdata[`ACC_BIT_RESULT] = cmp_level;
            nxt_prdata[`ACC_BIT_RISE]   = rise_edge_flag_ff;
            nxt_prdata[`ACC_BIT_FALL]   = fall_edge_flag_ff;
            nxt_prdata[3:2]             = pos_hyst_sel;
            nxt_prdata[1:0]             = neg_hyst_sel;
          end
          `ACC_MODE_ADDR:
            nxt_prdata[1:0] = response_mode;
          `ACC_IRQ_STAT_ADDR:
            nxt_prdata[1:0] = {fall_stat_ff, rise_stat_ff};
          `ACC_IRQ_MASK_ADDR:
            nxt_prdata[1:0] = {fall_irq_mask_en_ff, rise_irq_mask_en_ff};
          default:
            nxt_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      comparator_on       <= 1'b0;
      pos_hyst_sel        <= 2'h0;
      neg_hyst_sel        <= 2'h0;
      response_mode       <= `ACC_MODE_RESET;
      rise_edge_flag_ff   <= 1'b0;
      fall_edge_flag_ff   <= 1'b0;
      rise_irq_mask_en_ff <= 1'b0;
      fall_irq_mask_en_ff <= 1'b0;
      rise_stat_ff        <= 1'b0;
      fall_stat_ff        <= 1'b0;
      prdata              <= 32'h0000_0000;
      pready              <= 1'b0;
      pslverr             <= 1'b0;
      irq                 <= 1'b0;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= nxt_slverr;
      prdata  <= nxt_prdata;
      if (wr_go && lane0)
      begin
        case (paddr)
          `ACC_CTRL_ADDR:
          begin
            comparator_on <= pwdata[`ACC_BIT_ON];
            pos_hyst_sel  <= pwdata[`ACC_POS_HI:`ACC_POS_LO];
            neg_hyst_sel  <= pwdata[`ACC_NEG_HI:`ACC_NEG_LO];
          end
          `ACC_MODE_ADDR:
            response_mode <= pwdata[1:0];
          `ACC_IRQ_MASK_ADDR:
          begin
            rise_irq_mask_en_ff <= pwdata[`ACC_IRQ_RISE];
            fall_irq_mask_en_ff <= pwdata[`ACC_IRQ_FALL];
          end
          default:
            comparator_on <= comparator_on;
        endcase
      end
      rise_edge_flag_ff <= nxt_rise_flag;
      fall_edge_flag_ff <= nxt_fall_flag;
      rise_stat_ff      <= nxt_rise_stat;
      fall_stat_ff      <= nxt_fall_stat;
      // level request from sticky status gated by masks
      irq <= (nxt_rise_stat & nxt_rise_mask) |
             (nxt_fall_stat & nxt_fall_mask);
    end
  end

endmodule

`default_nettype wire

// ===== dv/acc_core_model.sv
// analog comparator core model: output is plus above minus, low when off
// assumes the bench sets the input relation
`timescale 1ns/1ps
`default_nettype none
module acc_core_model
(
  input  wire logic comparator_on,
  input  wire logic plus_above,
  output logic      cmp_raw
);
  // a powered-down core holds its output low
  assign cmp_raw = comparator_on & plus_above;
endmodule
`default_nettype wire

// ===== dv/acc_top_chk.sv
// checker: apb timing and register effects at the top's ports
// assumes only the ports of acc_top; bound below
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.vh"
module acc_top_chk
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cmp_raw,
  input wire logic        comparator_on,
  input wire logic [1:0]  pos_hyst_sel,
  input wire logic [1:0]  neg_hyst_sel,
  input wire logic [1:0]  response_mode,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic       wr;
  logic       cmp_d_ff;
  logic [2:0] stab_ff;
  assign wr = psel && penable && !pready && pwrite && pstrb[0];
  // cycles since the raw output last changed
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      cmp_d_ff <= 1'b0;
      stab_ff  <= 3'h0;
    end
    else
    begin
      cmp_d_ff <= cmp_raw;
      stab_ff  <= (cmp_raw != cmp_d_ff) ? 3'h0 : ((stab_ff == 3'h7) ? stab_ff : stab_ff + 3'h1);
    end
  a_ready_wait: assert property ($rose(penable) && psel |=> pready) else $error("late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_ctrl_on: assert property (wr && paddr == `ACC_CTRL_ADDR
    |=> comparator_on == $past(pwdata[7])) else $error("enable");
  a_pos_hyst: assert property (wr && paddr == `ACC_CTRL_ADDR
    |=> pos_hyst_sel == $past(pwdata[3:2])) else $error("pos hyst");
  a_neg_hyst: assert property (wr && paddr == `ACC_CTRL_ADDR
    |=> neg_hyst_sel == $past(pwdata[1:0])) else $error("neg hyst");
  a_mode_set: assert property (wr && paddr == `ACC_MODE_ADDR
    |=> response_mode == $past(pwdata[1:0])) else $error("mode");
  a_bad_addr: assert property (pready && !(paddr inside {`ACC_CTRL_ADDR, `ACC_MODE_ADDR,
    `ACC_IRQ_STAT_ADDR, `ACC_IRQ_MASK_ADDR}) |-> pslverr && prdata == 32'h0) else $error("err");
  a_result_live: assert property (pready && !pwrite && paddr == `ACC_CTRL_ADDR
    && stab_ff > 3'h5 |-> prdata[6] == cmp_raw) else $error("result");
  a_irq_hold: assert property ($fell(irq) |-> $past(wr)) else $error("irq dropped");
endmodule
bind acc_top acc_top_chk u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw), .comparator_on(comparator_on),
  .pos_hyst_sel(pos_hyst_sel), .neg_hyst_sel(neg_hyst_sel), .response_mode(response_mode),
  .irq(irq));
`default_nettype wire

// ===== dv/acc_top_tb.sv
// testbench: apb register tests of the comparator control block
// assumes acc_top and the core model; one clock
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.vh"
module acc_top_tb;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        plus_above = 1'b0, err, cmp_raw, comparator_on, pready, pslverr, irq;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0]  pos_hyst_sel, neg_hyst_sel, response_mode;
  int          n_fail = 0, compares = 0;
  always #10 clk = ~clk;
  acc_top u_acc_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_raw(cmp_raw), .comparator_on(comparator_on),
    .pos_hyst_sel(pos_hyst_sel), .neg_hyst_sel(neg_hyst_sel), .response_mode(response_mode),
    .irq(irq));
  acc_core_model u_acc_core_model (.comparator_on(comparator_on), .plus_above(plus_above),
    .cmp_raw(cmp_raw));
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic close_out;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_fail++;
    close_out;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdchk(`ACC_CTRL_ADDR, 32'h0);
    rdchk(`ACC_MODE_ADDR, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, `ACC_CTRL_ADDR, 32'h80 | (i << 2) | (3 - i));
      chk({comparator_on, pos_hyst_sel, neg_hyst_sel}, 32'h10 | (i << 2) | (3 - i));
      apb(1'b1, `ACC_MODE_ADDR, i);
      chk(response_mode, i);
    end
    apb(1'b1, `ACC_IRQ_MASK_ADDR, 32'h3);
    plus_above <= 1'b1;
    repeat (8) @(posedge clk);
    chk(irq, 1);
    rdchk(`ACC_CTRL_ADDR, 32'hec);
    rdchk(`ACC_IRQ_STAT_ADDR, 32'h1);
    apb(1'b1, `ACC_IRQ_STAT_ADDR, 32'h1);
    chk(irq, 0);
    rdchk(`ACC_CTRL_ADDR, 32'hec);
    apb(1'b1, `ACC_CTRL_ADDR, 32'h8c);
    rdchk(`ACC_CTRL_ADDR, 32'hcc);
    apb(1'b1, `ACC_IRQ_MASK_ADDR, 32'h1);
    plus_above <= 1'b0;
    repeat (8) @(posedge clk);
    chk(irq, 0);
    rdchk(`ACC_CTRL_ADDR, 32'h9c);
    rdchk(`ACC_IRQ_STAT_ADDR, 32'h2);
    apb(1'b1, `ACC_IRQ_MASK_ADDR, 32'h2);
    chk(irq, 1);
    apb(1'b1, `ACC_CTRL_ADDR, 32'h0c);
    chk(comparator_on, 0);
    rdchk(12'h300, 32'h0);
    chk(err, 1);
    close_out;
  end
endmodule
`default_nettype wire
